// ===== logic/habs_top.sv
// host address bus: decode, strap capture and outward drive control
// =========================================================================
// Contract
// - large memory: line 12 is always an address bit.
// - small memory, upper strap high: line 12 is address bit 12.
// - small memory, upper strap low: line 12 is the boot strap.
// - boot strap low: come up as terminal with busy set.
// - boot strap high: idle if terminal-only, else bus controller.
// - host decodes bits 11..0, plus 15..12 in large memory or with upper strap high.
// - buffered mode: never drive address lines.
// - transparent mode: drive address out during protocol RAM access.
// - drive only while ram ack low and io cycle flag high.
// - otherwise and after reset the lines stay undriven.
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none
module habs_top
    import habs_pkg::*;
#(
    parameter bit LARGE_MEM = 1'b0,
    parameter bit FULL_FUNC = 1'b1
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    // address pins
    input wire logic [ADDR_W-1:0] ADDR_PIN_I,
    output logic [ADDR_W-1:0] ADDR_PIN_O,
    output logic [ADDR_W-1:0] ADDR_PIN_OE_O,
    // straps and protocol-side control
    input wire logic UPPER_ADDRESS_LINES_STRAP_I,
    input wire logic RAM_BUS_OWNED_ACK_I,
    input wire logic HOST_IO_CYCLE_ACTIVE_I,
    input wire logic [ADDR_W-1:0] PROTO_ADDR_I,
    // decoded host address and boot result
    output logic [ADDR_W-1:0] HOST_ADDR_O,
    output logic [2:0] BOOT_MODE_O,
    output logic BOOT_VALID_O,
    // register port
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [15:0] REG_RDATA_O
);
    // =====================================================================
    // synchronised pins
    logic [ADDR_W-1:0] pin_s;
    logic [2:0] ctl_s;
    habs_sync #(.W(ADDR_W)) u_sync_addr (
        .clk_i(MCLK_I),
        .rst_b_i(RST_B_I),
        .d_i(ADDR_PIN_I),
        .q_o(pin_s)
    );
    habs_sync #(.W(3)) u_sync_ctl (
        .clk_i(MCLK_I),
        .rst_b_i(RST_B_I),
        .d_i({UPPER_ADDRESS_LINES_STRAP_I, RAM_BUS_OWNED_ACK_I, HOST_IO_CYCLE_ACTIVE_I}),
        .q_o(ctl_s)
    );
    logic up_s, ack_s, io_s;
    assign up_s = ctl_s[2];
    assign ack_s = ctl_s[1];
    assign io_s = ctl_s[0];

    // =====================================================================
    // strap capture, once after reset release
    // synchroniser output is valid two edges after release; wait for it
    logic [1:0] wait_r;
    logic cap_done_r;
    logic upper_en_r;
    logic boot_strap_r;
    logic vcc_strap_r;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            wait_r <= 2'h0;
        end else if (wait_r != SYNC_SETTLE) begin
            wait_r <= wait_r + SETTLE_STEP;
        end
    end
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            cap_done_r <= 1'b0;
            upper_en_r <= 1'b0;
            boot_strap_r <= 1'b0;
            vcc_strap_r <= 1'b0;
        end else if (!cap_done_r && wait_r == SYNC_SETTLE) begin
            cap_done_r <= 1'b1;
            upper_en_r <= LARGE_MEM | up_s;
            boot_strap_r <= pin_s[BOOT_BIT];
            vcc_strap_r <= pin_s[VCC_BIT];
        end
    end

    // =====================================================================
    // boot mode
    function automatic logic [2:0] boot_of(input logic strap, input logic full);
        if (!strap) begin
            boot_of = HABS_BOOT_RT_BUSY;
        end else if (full) begin
            boot_of = HABS_BOOT_BC;
        end else begin
            boot_of = HABS_BOOT_IDLE;
        end
    endfunction

    logic [2:0] boot_nxt;
    always_comb begin
        // large memory or upper strap high: no boot strap, default terminal
        if (upper_en_r) begin
            boot_nxt = HABS_BOOT_RT_BUSY;
        end else begin
            boot_nxt = boot_of(boot_strap_r, FULL_FUNC);
        end
    end
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            BOOT_MODE_O <= HABS_BOOT_RT_BUSY;
            BOOT_VALID_O <= 1'b0;
        end else begin
            BOOT_MODE_O <= boot_nxt;
            BOOT_VALID_O <= cap_done_r;
        end
    end

    // =====================================================================
    // host address decode
    logic [ADDR_W-1:0] host_nxt;
    always_comb begin
        host_nxt = '0;
        host_nxt[LOW_ADDR_W-1:0] = pin_s[LOW_ADDR_W-1:0];
        if (upper_en_r) begin
            host_nxt[ADDR_W-1:UP_LO_BIT] = pin_s[ADDR_W-1:UP_LO_BIT];
        end
    end
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            HOST_ADDR_O <= '0;
        end else begin
            HOST_ADDR_O <= host_nxt;
        end
    end

    // =====================================================================
    // control register and outward drive
    logic [15:0] ctrl_r;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ctrl_r <= CTRL_RST;
        end else if (REG_WR_I && REG_ADDR_I == REG_CTRL) begin
            ctrl_r <= REG_WDATA_I;
        end
    end
    logic transp;
    assign transp = ctrl_r[CTRL_TRANSP];

    // mask limits drive to lines 12..0, boot strap line included, or to all lines when the upper lines are address bits
    logic [ADDR_W-1:0] drv_mask;
    always_comb begin
        drv_mask = '0;
        drv_mask[BOOT_BIT:0] = '1;
        if (upper_en_r) begin
            drv_mask = '1;
        end else if (!cap_done_r) begin
            drv_mask = '0;
        end
    end

    logic drive_nxt;
    logic drive_r;
    // buffered mode never drives; transparent only on protocol access
    assign drive_nxt = cap_done_r && transp && !ack_s && io_s;
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            drive_r <= 1'b0;
            ADDR_PIN_O <= '0;
            ADDR_PIN_OE_O <= '0;
        end else begin
            drive_r <= drive_nxt;
            ADDR_PIN_O <= PROTO_ADDR_I & drv_mask;
            ADDR_PIN_OE_O <= drive_nxt ? drv_mask : '0;
        end
    end

    // =====================================================================
    // register read
    always_ff @(posedge MCLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            REG_RDATA_O <= '0;
        end else if (REG_RD_I) begin
            case (REG_ADDR_I)
                REG_CTRL: REG_RDATA_O <= ctrl_r;
                REG_STAT: REG_RDATA_O <= {STAT_PAD, drive_r, vcc_strap_r, boot_strap_r,
                                          upper_en_r, cap_done_r, BOOT_MODE_O};
                REG_ADDR: REG_RDATA_O <= HOST_ADDR_O;
                REG_HOSTA: REG_RDATA_O <= pin_s;
                default: REG_RDATA_O <= '0;
            endcase
        end else begin
            REG_RDATA_O <= '0;
        end
    end
endmodule
`default_nettype wire

// ===== include/habs_pkg.sv
// constants for the host address bus and strap logic
`default_nettype none
package habs_pkg;
    // =====================================================================
    // bus geometry
    localparam int ADDR_W = 16;
    localparam int LOW_ADDR_W = 12;
    localparam int BOOT_BIT = 12;
    localparam int VCC_BIT = 13;
    localparam int UP_LO_BIT = 12;
    // capture waits this many edges after release before the straps are trusted; the synchroniser needs two
    localparam logic [1:0] SYNC_SETTLE = 2'h3;
    localparam logic [1:0] SETTLE_STEP = 2'h1;
    localparam logic [7:0] STAT_PAD = 8'h00;
    // =====================================================================
    // register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [3:0] REG_ADDR = 4'h2;
    localparam logic [3:0] REG_HOSTA = 4'h3;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam int CTRL_TRANSP = 0;
    // =====================================================================
    // power-up modes
    typedef enum logic [2:0] {
        HABS_BOOT_RT_BUSY = 3'b001,
        HABS_BOOT_IDLE = 3'b010,
        HABS_BOOT_BC = 3'b100
    } habs_boot_t;
endpackage
`default_nettype wire

// ===== logic/habs_sync.sv
// two-flop synchroniser for a bus of pin inputs
`default_nettype none
module habs_sync #(
    parameter int W = 16
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r <= '0;
            q_o <= '0;
        end else begin
            s1_r <= d_i;
            q_o <= s1_r;
        end
    end
endmodule
`default_nettype wire

// ===== test/habs_host_model.sv
// host cpu side of the address pins with the board strap tie
`default_nettype none
module habs_host_model (
    input wire logic small_i,
    input wire logic strap_i,
    input wire logic [15:0] host_i,
    input wire logic [15:0] oe_i,
    input wire logic [15:0] o_i,
    output logic [15:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] h;
    // line 13 is a supply tie while the upper lines are straps
    assign h = host_i | ((small_i && !strap_i) ? 16'h2000 : 16'h0000);
    assign pin_o = (oe_i & o_i) | (~oe_i & h);
endmodule
`default_nettype wire

// ===== test/habs_properties.sv
// checker for the address bus and strap logic
`default_nettype none
module habs_properties
    import habs_pkg::*;
#(parameter bit LARGE_MEM = 1'b0, parameter bit FULL_FUNC = 1'b1) (
    // watched ports
    input wire logic MCLK_I, RST_B_I, UPPER_ADDRESS_LINES_STRAP_I, REG_RD_I,
    input wire logic RAM_BUS_OWNED_ACK_I, HOST_IO_CYCLE_ACTIVE_I, BOOT_VALID_O,
    input wire logic [ADDR_W-1:0] ADDR_PIN_I, ADDR_PIN_O, ADDR_PIN_OE_O,
    input wire logic [ADDR_W-1:0] PROTO_ADDR_I, HOST_ADDR_O,
    input wire logic [15:0] REG_RDATA_O,
    input wire logic [3:0] REG_ADDR_I,
    input wire logic [2:0] BOOT_MODE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic up;
    logic [2:0] bx;
    assign up = LARGE_MEM || UPPER_ADDRESS_LINES_STRAP_I;
    assign bx = (up || !ADDR_PIN_I[BOOT_BIT]) ? HABS_BOOT_RT_BUSY
        : (FULL_FUNC ? HABS_BOOT_BC : HABS_BOOT_IDLE);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);
    oe_gate_a: assert property (
        ADDR_PIN_OE_O != 16'h0 |-> !$past(RAM_BUS_OWNED_ACK_I, 3)
        && $past(HOST_IO_CYCLE_ACTIVE_I, 3)) else $error("drive outside ram access");
    oe_mask_a: assert property (
        ADDR_PIN_OE_O != 16'h0 |-> ADDR_PIN_OE_O == (up ? 16'hFFFF : 16'h1FFF))
        else $error("wrong drive mask");
    drive_addr_a: assert property (
        ADDR_PIN_OE_O != 16'h0 |-> ADDR_PIN_O == ($past(PROTO_ADDR_I) & ADDR_PIN_OE_O))
        else $error("wrong outward address");
    quiet_boot_a: assert property (
        !BOOT_VALID_O |-> ADDR_PIN_OE_O == 16'h0) else $error("drive before capture");
    valid_time_a: assert property (
        $rose(RST_B_I) |-> !BOOT_VALID_O [*3] ##[1:4] BOOT_VALID_O)
        else $error("capture time wrong");
    boot_hold_a: assert property (
        BOOT_VALID_O |=> BOOT_VALID_O && $stable(BOOT_MODE_O)) else $error("boot changed");
    boot_mode_a: assert property (
        $rose(BOOT_VALID_O) |-> BOOT_MODE_O == bx) else $error("wrong boot mode");
    host_addr_a: assert property (
        BOOT_VALID_O |-> HOST_ADDR_O == ($past(ADDR_PIN_I, 3) & (up ? 16'hFFFF : 16'h0FFF)))
        else $error("wrong host address");
    rd_host_a: assert property (
        $past(REG_RD_I) && $past(REG_ADDR_I) == REG_ADDR |-> REG_RDATA_O == $past(HOST_ADDR_O))
        else $error("wrong address readback");
    cover property ($rose(BOOT_VALID_O));
    cover property ($rose(ADDR_PIN_OE_O[0]));
    cover property ($fell(ADDR_PIN_OE_O[0]));
endmodule
bind habs_top habs_properties #(.LARGE_MEM(LARGE_MEM), .FULL_FUNC(FULL_FUNC)) i_chk (.*);
`default_nettype wire

// ===== test/habs_top_tb.sv
// register-level bench for the address bus and strap logic
`default_nettype none
module habs_top_tb
    import habs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, strap, ack, io, wr, rd, bv;
    logic [15:0] host_a, proto, wdata, pin, po, oe, ha, rdata;
    logic [3:0] ra;
    logic [2:0] bm;
    int err_total = 0;
    int n_checks = 0;
    habs_host_model i_host (.small_i(1'b1), .strap_i(strap), .host_i(host_a), .oe_i(oe),
        .o_i(po), .pin_o(pin));
    habs_top i_dut (.MCLK_I(clk), .RST_B_I(rst_b), .ADDR_PIN_I(pin), .ADDR_PIN_O(po),
        .ADDR_PIN_OE_O(oe), .UPPER_ADDRESS_LINES_STRAP_I(strap), .RAM_BUS_OWNED_ACK_I(ack),
        .HOST_IO_CYCLE_ACTIVE_I(io), .PROTO_ADDR_I(proto), .HOST_ADDR_O(ha),
        .BOOT_MODE_O(bm), .BOOT_VALID_O(bv), .REG_ADDR_I(ra), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wrr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk) begin wr <= 1'b1; ra <= a; wdata <= d; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk) begin rd <= 1'b1; ra <= a; end
        @(posedge clk) rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask
    // straps are only looked at once, so every mode needs its own reset
    task automatic boot(input logic s, input logic [15:0] a);
        @(posedge clk) begin rst_b <= 1'b0; strap <= s; host_a <= a; end
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        #1 chk({15'h0, bv}, 16'h0001);
        chk(oe, 16'h0000);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial begin
        {rst_b, strap, ack, io, wr, rd} = 6'b000100;
        {host_a, proto, wdata, ra} = 52'h0;
        boot(1'b0, 16'hEA5A);
        chk({13'h0, bm}, 16'h0001);
        chk(ha, 16'h0A5A);
        rdc(REG_ADDR, 16'h0A5A);
        rdc(REG_STAT, 16'h0049);
        rdc(REG_HOSTA, 16'hEA5A);
        rdc(REG_CTRL, CTRL_RST);
        rdc(4'hF, 16'h0000);
        $display("end test strap low");
        {ack, io, proto} <= {2'b01, 16'h3456};
        settle();
        chk(oe, 16'h0000);
        wrr(REG_CTRL, 16'h0001);
        settle();
        chk(oe, 16'h1FFF);
        chk(po, 16'h1456);
        ack <= 1'b1;
        settle();
        chk(oe, 16'h0000);
        {ack, io} <= 2'b00;
        settle();
        chk(oe, 16'h0000);
        $display("end test drive");
        boot(1'b0, 16'h1000);
        chk({13'h0, bm}, 16'h0004);
        host_a <= 16'h0000;
        settle();
        chk({13'h0, bm}, 16'h0004);
        chk(ha, 16'h0000);
        $display("end test boot high");
        boot(1'b1, 16'hEA5A);
        chk(ha, 16'hEA5A);
        wrr(REG_CTRL, 16'h0001);
        io <= 1'b1;
        settle();
        chk(oe, 16'hFFFF);
        chk(po, 16'h3456);
        $display("end test upper lines");
        summarize();
    end
endmodule
`default_nettype wire
